// ### pkg/fpet_pkg.sv
// Constants for the flash program/erase host sequencer
package fpet_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 5;
  // Write pulse low and high widths, read access, reset timing
  localparam int unsigned T_WP_NS          = 70;
  localparam int unsigned T_WPH_NS         = 30;
  localparam int unsigned T_ACC_NS         = 110;
  localparam int unsigned T_RST_LOW_NS     = 100;
  localparam int unsigned T_RST_REC_NS     = 600;
  localparam int unsigned T_ABORT_US       = 22;
  localparam int unsigned T_PROG_MAX_US    = 200;
  localparam int unsigned WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPH_CYC  = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RLOW_CYC = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RREC_CYC = (T_RST_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ABORT_CYC = (T_ABORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_TO_CYC = (T_PROG_MAX_US * 1000) / CLK_PERIOD_NS;
  // Erase completion limit in clock cycles
  localparam int unsigned ERASE_TO_CYC = 16000000;
  localparam int unsigned CNT_W    = 24;
  localparam int unsigned ADDR_W   = 22;
  localparam int unsigned DATA_W   = 16;
  // Command codes
  localparam logic [15:0] CMD_PROG_SETUP  = 16'h0040;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
  localparam logic [15:0] CMD_ERASE_CONF  = 16'h00d0;
  localparam logic [15:0] CMD_READ_ARRAY  = 16'h00ff;
  localparam int unsigned ST_READY_BIT    = 7;
  localparam int unsigned ST_ERR_LO       = 1;
  localparam int unsigned ST_ERR_HI       = 5;
  typedef enum logic [3:0] {
    FPET_IDLE = 4'h0, FPET_W1 = 4'h1, FPET_G1 = 4'h3, FPET_W2 = 4'h2,
    FPET_G2 = 4'h6, FPET_POLL = 4'h7, FPET_PGAP = 4'hf, FPET_RA = 4'h5,
    FPET_GRA = 4'h4, FPET_RST = 4'hd, FPET_REC = 4'hc
  } fpet_state_t;
endpackage

// ### hw/fpet_host.sv
// Host sequencer that programs or erases an asynchronous NOR flash
`timescale 1ns/10ps
module fpet_host #(
  parameter int unsigned PROG_TO = fpet_pkg::PROG_TO_CYC,
  parameter int unsigned ERASE_TO = fpet_pkg::ERASE_TO_CYC,
  parameter int unsigned ABORT_WAIT = fpet_pkg::ABORT_CYC
) (
  // Clock and reset
  input  wire logic                        MCLK_I,
  input  wire logic                        RESET_I,
  // Command port
  input  wire logic                        START_I,
  input  wire logic                        ERASE_I,
  input  wire logic                        ABORT_I,
  input  wire logic [fpet_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [fpet_pkg::DATA_W-1:0] DATA_I,
  output logic                             BUSY_O,
  output logic                             DONE_O,
  output logic                             FAIL_O,
  output logic                             TIMEOUT_O,
  // Flash pins
  output logic                             CE_N_O,
  output logic                             WE_N_O,
  output logic                             OE_N_O,
  output logic                             RESET_POWERDOWN_N_O,
  output logic [fpet_pkg::ADDR_W-1:0]      FA_O,
  output logic [fpet_pkg::DATA_W-1:0]      FD_O,
  output logic                             FD_OE_O,
  input  wire logic [fpet_pkg::DATA_W-1:0] FD_I
);
  typedef struct packed {
    fpet_pkg::fpet_state_t     st;
    logic [fpet_pkg::CNT_W-1:0] cnt;
    logic [31:0]               to;
    logic                      erase;
    logic [fpet_pkg::ADDR_W-1:0] addr;
    logic [fpet_pkg::DATA_W-1:0] data;
    logic                      ce_n, we_n, oe_n, rp_n, fd_oe;
    logic [fpet_pkg::DATA_W-1:0] fd;
    logic                      busy, done, fail, tout;
    logic [fpet_pkg::DATA_W-1:0] s1, s2;
  } fpet_s_t;
  fpet_s_t s_reg, s_next;
  logic ready, bad;
  assign ready = s_reg.s2[fpet_pkg::ST_READY_BIT];
  assign bad   = |s_reg.s2[fpet_pkg::ST_ERR_HI:fpet_pkg::ST_ERR_LO];

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.s1 = FD_I;
    s_next.s2 = s_reg.s1;
    s_next.done = 1'b0;
    if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
    if (s_reg.to != '0) begin
      s_next.to = s_reg.to - 1'b1;
    end
    case (s_reg.st)
      fpet_pkg::FPET_IDLE: begin
        s_next.busy = 1'b0;
        if (START_I) begin
          s_next.busy = 1'b1;
          s_next.fail = 1'b0;
          s_next.tout = 1'b0;
          s_next.erase = ERASE_I;
          s_next.addr = ADDR_I;
          s_next.data = DATA_I;
          s_next.fd = ERASE_I ? fpet_pkg::CMD_ERASE_SETUP : fpet_pkg::CMD_PROG_SETUP;
          s_next.fd_oe = 1'b1;
          s_next.ce_n = 1'b0;
          s_next.we_n = 1'b0;
          s_next.cnt = fpet_pkg::CNT_W'(fpet_pkg::WP_CYC);
          s_next.st = fpet_pkg::FPET_W1;
        end
      end
      fpet_pkg::FPET_W1, fpet_pkg::FPET_W2, fpet_pkg::FPET_RA: begin
        if (s_reg.cnt == '0) begin
          // Both strobes rise together, ending the write cycle
          s_next.we_n = 1'b1;
          s_next.ce_n = 1'b1;
          s_next.cnt = fpet_pkg::CNT_W'(fpet_pkg::WPH_CYC);
          s_next.st = (s_reg.st == fpet_pkg::FPET_W1) ? fpet_pkg::FPET_G1 :
                      (s_reg.st == fpet_pkg::FPET_W2) ? fpet_pkg::FPET_G2 : fpet_pkg::FPET_GRA;
        end
      end
      fpet_pkg::FPET_G1: begin
        if (s_reg.cnt == '0) begin
          s_next.addr = s_reg.addr;
          s_next.fd = s_reg.erase ? fpet_pkg::CMD_ERASE_CONF : s_reg.data;
          s_next.ce_n = 1'b0;
          s_next.we_n = 1'b0;
          s_next.cnt = fpet_pkg::CNT_W'(fpet_pkg::WP_CYC);
          s_next.to = s_reg.erase ? ERASE_TO : PROG_TO;
          s_next.st = fpet_pkg::FPET_W2;
        end
      end
      fpet_pkg::FPET_G2, fpet_pkg::FPET_PGAP: begin
        if (s_reg.cnt == '0) begin
          // Fresh chip select for each poll, write strobe high
          s_next.fd_oe = 1'b0;
          s_next.ce_n = 1'b0;
          s_next.oe_n = 1'b0;
          s_next.we_n = 1'b1;
          s_next.cnt = fpet_pkg::CNT_W'(fpet_pkg::ACC_CYC + 2);
          s_next.st = fpet_pkg::FPET_POLL;
        end
      end
      fpet_pkg::FPET_POLL: begin
        if (s_reg.cnt == '0) begin
          s_next.ce_n = 1'b1;
          s_next.oe_n = 1'b1;
          s_next.cnt = fpet_pkg::CNT_W'(fpet_pkg::WPH_CYC);
          if (ready) begin
            s_next.fail = bad;
            s_next.fd = fpet_pkg::CMD_READ_ARRAY;
            s_next.fd_oe = 1'b1;
            s_next.st = fpet_pkg::FPET_RA;
            s_next.ce_n = 1'b0;
            s_next.we_n = 1'b0;
            s_next.cnt = fpet_pkg::CNT_W'(fpet_pkg::WP_CYC);
          end else if (s_reg.to == '0) begin
            s_next.tout = 1'b1;
            s_next.rp_n = 1'b0;
            s_next.cnt = fpet_pkg::CNT_W'(fpet_pkg::RLOW_CYC);
            s_next.st = fpet_pkg::FPET_RST;
          end else begin
            s_next.st = fpet_pkg::FPET_PGAP;
          end
        end
      end
      fpet_pkg::FPET_GRA: begin
        if (s_reg.cnt == '0) begin
          s_next.fd_oe = 1'b0;
          s_next.done = 1'b1;
          s_next.busy = 1'b0;
          s_next.st = fpet_pkg::FPET_IDLE;
        end
      end
      fpet_pkg::FPET_RST: begin
        if (s_reg.cnt == '0) begin
          s_next.rp_n = 1'b1;
          // Abort inside an operation needs the long wait
          s_next.cnt = fpet_pkg::CNT_W'(ABORT_WAIT + fpet_pkg::RREC_CYC);
          s_next.st = fpet_pkg::FPET_REC;
        end
      end
      fpet_pkg::FPET_REC: begin
        if (s_reg.cnt == '0) begin
          s_next.done = 1'b1;
          s_next.busy = 1'b0;
          s_next.fail = 1'b1;
          s_next.st = fpet_pkg::FPET_IDLE;
        end
      end
      default: s_next.st = fpet_pkg::FPET_IDLE;
    endcase
    if (ABORT_I && s_reg.busy && s_reg.st != fpet_pkg::FPET_RST && s_reg.st != fpet_pkg::FPET_REC) begin
      s_next.ce_n = 1'b1;
      s_next.we_n = 1'b1;
      s_next.oe_n = 1'b1;
      s_next.fd_oe = 1'b0;
      s_next.rp_n = 1'b0;
      s_next.cnt = fpet_pkg::CNT_W'(fpet_pkg::RLOW_CYC);
      s_next.st = fpet_pkg::FPET_RST;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      s_reg <= '0;
      s_reg.st <= fpet_pkg::FPET_IDLE;
      s_reg.ce_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.oe_n <= 1'b1;
      s_reg.rp_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign BUSY_O = s_reg.busy;
  assign DONE_O = s_reg.done;
  assign FAIL_O = s_reg.fail;
  assign TIMEOUT_O = s_reg.tout;
  assign CE_N_O = s_reg.ce_n;
  assign WE_N_O = s_reg.we_n;
  assign OE_N_O = s_reg.oe_n;
  assign RESET_POWERDOWN_N_O = s_reg.rp_n;
  assign FA_O = s_reg.addr;
  assign FD_O = s_reg.fd;
  assign FD_OE_O = s_reg.fd_oe;

  // ****************************************
  // Checks
  // ****************************************
  property p_setup_first;
    @(posedge MCLK_I) disable iff (RESET_I)
    (s_reg.st == fpet_pkg::FPET_IDLE && START_I && !ABORT_I) |=> (!WE_N_O && FD_OE_O &&
      (FD_O == fpet_pkg::CMD_PROG_SETUP || FD_O == fpet_pkg::CMD_ERASE_SETUP));
  endproperty
  a_setup_first: assert property (p_setup_first) else $error("Setup write missing");
  property p_second;
    @(posedge MCLK_I) disable iff (RESET_I)
    (s_reg.st == fpet_pkg::FPET_W2 && s_reg.erase) |-> FD_O == fpet_pkg::CMD_ERASE_CONF;
  endproperty
  a_second: assert property (p_second) else $error("Erase confirm wrong");
  property p_poll_we;
    @(posedge MCLK_I) disable iff (RESET_I)
    (!OE_N_O) |-> (WE_N_O && !FD_OE_O);
  endproperty
  a_poll_we: assert property (p_poll_we) else $error("Write strobe low in read");
  property p_poll_ce;
    @(posedge MCLK_I) disable iff (RESET_I)
    ($fell(OE_N_O)) |-> $fell(CE_N_O);
  endproperty
  a_poll_ce: assert property (p_poll_ce) else $error("Poll without fresh select");
  property p_rst_low;
    @(posedge MCLK_I) disable iff (RESET_I)
    $fell(RESET_POWERDOWN_N_O) |-> !RESET_POWERDOWN_N_O [*8];
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("Reset pulse too short");
  property p_wp;
    @(posedge MCLK_I) disable iff (RESET_I)
    // An abort may cut a write pulse short; the reset pin then covers it
    ($fell(WE_N_O) && !ABORT_I) |-> ((!WE_N_O && !CE_N_O) || !RESET_POWERDOWN_N_O) [*8];
  endproperty
  a_wp: assert property (p_wp) else $error("Write pulse too short");
  property p_ra;
    @(posedge MCLK_I) disable iff (RESET_I)
    $rose(DONE_O) && !FAIL_O |-> $past(s_reg.st) == fpet_pkg::FPET_GRA;
  endproperty
  a_ra: assert property (p_ra) else $error("Done without read array");
  property p_to;
    @(posedge MCLK_I) disable iff (RESET_I)
    $rose(TIMEOUT_O) |-> !RESET_POWERDOWN_N_O;
  endproperty
  a_to: assert property (p_to) else $error("Timeout without reset");
endmodule

// ### bench/fpet_flash_model.sv
// Behavioural flash device seen through its control pins
`timescale 1ns/10ps
module fpet_flash_model (
  // Flash pins
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        rp_n_i,
  input  wire logic [15:0] fd_i,
  output logic      [15:0] q_o,
  // Behaviour knobs
  input  wire logic        err_i,
  input  wire logic        hang_i,
  input  wire logic [7:0]  polls_i
);
  // ****************
  // Command tracking
  // ****************
  logic [15:0] wlog[$];
  int          reads;
  int          bad_reads;
  int          rp_low_ns;
  int          left;
  logic        busy;
  logic        arm;
  logic        wlow;
  logic        rlow;
  realtime     t_rp;
  wire         wr_n = ce_n_i | we_n_i;
  wire         rdy  = !busy || (left == 0 && !hang_i);
  initial begin
    reads = 0; bad_reads = 0; rp_low_ns = 0; left = 0;
    busy = 0; arm = 0; wlow = 0; rlow = 0; t_rp = 0; q_o = 16'h5a5a;
  end
  always @(negedge wr_n) wlow = 1;
  // Logged only at the end of a real low pulse, never on power-up
  always @(posedge wr_n) if (wlow && rp_n_i === 1'b1) begin
    wlow = 0;
    wlog.push_back(fd_i);
    if (arm) begin
      busy = 1; left = polls_i; arm = 0;
    end else if (fd_i == 16'h00ff) busy = 0;
    else arm = (fd_i == 16'h0040) || (fd_i == 16'h0020);
  end
  always @(negedge oe_n_i) rlow = 1;
  // Looked at a moment later: read end and write start share one clock edge
  always @(negedge we_n_i) #1 if (!oe_n_i) bad_reads++;
  always @(posedge ce_n_i) if (rlow) begin
    rlow = 0; reads++;
    if (busy && left > 0) left--;
  end
  // Released bus shows the inverse of what it last carried
  always @(ce_n_i or oe_n_i or rp_n_i or left or busy or hang_i)
    q_o <= (!ce_n_i && !oe_n_i && rp_n_i) ? {8'h00, rdy, 2'b00, err_i & rdy, 4'h0} : ~q_o;
  always @(negedge rp_n_i) begin
    t_rp = $realtime; busy = 0; arm = 0;
  end
  always @(posedge rp_n_i) if (t_rp > 0) rp_low_ns = int'($realtime - t_rp);
endmodule

// ### bench/fpet_host_test.sv
// Self-checking bench for the flash program/erase host sequencer
`timescale 1ns/10ps
module fpet_host_test;
  logic        clk = 0, rst = 1, start = 0, erase = 0, abort = 0, err = 0, hang = 0;
  logic [21:0] addr = '0;
  logic [15:0] data = '0;
  logic [7:0]  polls = '0;
  logic [15:0] fd_o, fd_i;
  logic [21:0] fa;
  logic        busy, done, fail, tmo, ce_n, we_n, oe_n, rp_n, fd_oe;
  int          bad_count = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  fpet_host #(.PROG_TO(2000), .ERASE_TO(2000), .ABORT_WAIT(5)) u_fpet_host (
    .MCLK_I(clk), .RESET_I(rst), .START_I(start), .ERASE_I(erase), .ABORT_I(abort),
    .ADDR_I(addr), .DATA_I(data), .BUSY_O(busy), .DONE_O(done), .FAIL_O(fail),
    .TIMEOUT_O(tmo), .CE_N_O(ce_n), .WE_N_O(we_n), .OE_N_O(oe_n),
    .RESET_POWERDOWN_N_O(rp_n), .FA_O(fa), .FD_O(fd_o), .FD_OE_O(fd_oe), .FD_I(fd_i));
  fpet_flash_model u_fpet_flash_model (
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .rp_n_i(rp_n), .fd_i(fd_o),
    .q_o(fd_i), .err_i(err), .hang_i(hang), .polls_i(polls));
  // ***************
  // Shared helpers
  // ***************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // START held two cycles: the second is refused while busy
  task automatic run(input logic er, input logic [15:0] d, input int p, input logic e, h, input int ab);
    int i;
    u_fpet_flash_model.wlog.delete();
    u_fpet_flash_model.reads = 0;
    u_fpet_flash_model.rp_low_ns = 0;
    polls = p[7:0]; err = e; hang = h;
    erase = er; addr = 22'h2a5a5; data = d; start = 1;
    @(negedge clk);
    @(negedge clk);
    start = 0;
    chk(busy, 1, "busy level");
    i = 0;
    while (done !== 1'b1 && i < 8000) begin
      abort = (i == ab);
      @(negedge clk);
      i++;
    end
    abort = 0;
    chk(i < 8000, 1, "done pulse");
    chk(busy, 0, "busy cleared");
    chk(fa, 22'h2a5a5, "target address");
  endtask
  task automatic seq3(input logic [15:0] c0, c1);
    chk(u_fpet_flash_model.wlog.size(), 3, "write count");
    chk(u_fpet_flash_model.wlog[0], c0, "setup write");
    chk(u_fpet_flash_model.wlog[1], c1, "second write");
    chk(u_fpet_flash_model.wlog[2], 16'h00ff, "read array");
  endtask
  // **********
  // Scenarios
  // **********
  task automatic s_prog;
    run(0, 16'h1234, 2, 0, 0, -1);
    seq3(16'h0040, 16'h1234);
    chk(u_fpet_flash_model.reads, 3, "poll count");
    chk(u_fpet_flash_model.bad_reads, 0, "strobe in read");
    chk({fail, tmo}, 0, "clean flags");
  endtask
  task automatic s_erase_b2b;
    run(1, 16'h00d0, 0, 0, 0, -1);
    seq3(16'h0020, 16'h00d0);
    chk(u_fpet_flash_model.reads, 1, "single poll");
  endtask
  task automatic s_err;
    run(0, 16'hbeef, 1, 1, 0, -1);
    chk({fail, tmo}, 2'b10, "error flags");
  endtask
  task automatic s_tmo;
    run(0, 16'h0001, 0, 0, 1, -1);
    chk({fail, tmo}, 2'b11, "timeout flags");
    chk(u_fpet_flash_model.rp_low_ns >= 100, 1, "reset width");
  endtask
  task automatic s_abort;
    run(1, 16'h00d0, 0, 0, 1, 60);
    chk({fail, tmo}, 2'b10, "abort flags");
    chk(u_fpet_flash_model.rp_low_ns >= 100, 1, "abort width");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    chk({ce_n, we_n, oe_n, rp_n, fd_oe}, 5'b11110, "idle pins");
    s_prog();
    s_erase_b2b();
    s_err();
    s_tmo();
    s_abort();
    s_prog();
    close_out();
  end
  initial begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule
